// ### rtl/event_irq_defines.vh
// Purpose: Shared offsets, field positions and reset values of the alert and checker block
// Assumes: 7-bit register addresses, 8-bit registers
// Notes:   Included by the checker and top design files of the block
`ifndef EVENT_IRQ_DEFINES_VH
`define EVENT_IRQ_DEFINES_VH

// Register offsets
`define ADDR_CONFIG        7'h00
`define ADDR_ALERT_EN_A    7'h04
`define ADDR_ALERT_EN_B    7'h05
`define ADDR_EVENT_A       7'h06
`define ADDR_EVENT_B       7'h07
`define ADDR_CHECK_CTRL    7'h67
`define ADDR_CMP_FIRST     7'h68
`define ADDR_CMP_LAST      7'h6F
`define ADDR_HIST_FIRST    7'h70
`define ADDR_HIST_LAST     7'h73

// Field positions
`define CFG_SOFT_RESET     5
`define CHK_ENABLE         7
`define CHK_AUTO_CLEAR     3
`define CHK_ERR_DETECTED   5
`define CHK_FAIL           1
`define CHK_PASS           0
`define EVB_ERR_DETECTED   2
`define EVB_FAIL           1
`define EVB_PASS           0

// Reset values
`define RST_ALERT_EN       8'h00
`define RST_CHECK_CTRL     8'h00
`define RST_CMP_BYTE       8'h00

// Serial frame and checker pass set count
`define INSTR_BITS         8
`define FRAME_BITS         16
`define PASS_SETS          4'h8

`endif

// ### rtl/event_flag_bank.v
// Purpose: Bank of event flags, latched or live per alert enable
// Assumes: Sources on the same clock as the bank
// Notes:   Set wins over a write-one clear in the same cycle
`timescale 1ns/10ps
module event_flag_bank #(
    parameter WIDTH = 8
) (
    input  wire             clk,
    input  wire             reset,
    input  wire             soft_rst,
    input  wire [WIDTH-1:0] source,
    input  wire [WIDTH-1:0] enable,
    input  wire [WIDTH-1:0] clear_ones,
    output wire [WIDTH-1:0] flag_view,
    output wire             pending
);
    reg  [WIDTH-1:0] source_prev;
    reg  [WIDTH-1:0] latched;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
            always @(posedge clk) begin
                if (reset || soft_rst) begin
                    latched[i]     <= 1'b0;
                    source_prev[i] <= 1'b0;
                end else begin
                    source_prev[i] <= source[i];
                    if (enable[i] && source[i] && !source_prev[i])
                        latched[i] <= 1'b1;
                    else if (clear_ones[i])
                        latched[i] <= 1'b0;
                end
            end
            // Live view when alerting is off
            assign flag_view[i] = enable[i] ? latched[i] : source[i];
        end
    endgenerate

    assign pending = |(latched & enable);
endmodule // event_flag_bank

// ### rtl/sample_checker.v
// Purpose: Compares captured input bytes against a stored comparison set
// Assumes: Inputs already synchronised to clk, one byte per valid pulse
// Notes:   Pass and fail only move in auto clear mode
`timescale 1ns/10ps
`include "event_irq_defines.vh"
module sample_checker (
    input  wire        clk,
    input  wire        reset,
    input  wire        soft_rst,
    input  wire        enable,
    input  wire        auto_mode,
    input  wire [7:0]  data,
    input  wire        valid,
    input  wire        frame,
    input  wire [63:0] cmp_set,
    input  wire        clr_err,
    input  wire        clr_pass,
    input  wire        clr_fail,
    input  wire [31:0] hist_clr,
    output reg         err_detected,
    output reg         cmp_pass,
    output reg         cmp_fail,
    output reg  [31:0] history
);
    reg        frame_prev;
    reg        aligned;
    reg        armed;
    reg        set_bad;
    reg  [2:0] idx;
    reg  [3:0] clean_sets;
    reg  [31:0] next_history;

    wire       start    = frame && !frame_prev;
    wire [2:0] cur_idx  = start ? 3'h0 : idx;
    wire       hit      = enable && valid && (start || aligned);
    wire [7:0] expected = cmp_set[cur_idx*8 +: 8];
    wire [7:0] diff     = hit ? (data ^ expected) : 8'h00;
    wire       set_done = hit && (cur_idx == 3'h7);
    wire       set_err  = set_bad || (|diff);
    wire       set_ok   = set_done && !set_err;
    wire       eight_ok = set_ok && auto_mode && (clean_sets == `PASS_SETS - 4'h1);

    always @* begin
        next_history = history & ~hist_clr;
        if (eight_ok)
            next_history = 32'h0000_0000;
        next_history[cur_idx[1:0]*8 +: 8] = next_history[cur_idx[1:0]*8 +: 8] | diff;
    end

    always @(posedge clk) begin
        if (reset || soft_rst || !enable) begin
            frame_prev   <= 1'b0;
            aligned      <= 1'b0;
            idx          <= 3'h0;
            set_bad      <= 1'b0;
            clean_sets   <= 4'h0;
            armed        <= 1'b0;
            cmp_pass     <= 1'b0;
            cmp_fail     <= 1'b0;
            history      <= next_history;
            err_detected <= (reset || soft_rst) ? 1'b0 : (err_detected && !clr_err);
            if (reset || soft_rst)
                history <= 32'h0000_0000;
        end else begin
            history <= next_history;
            if (valid) begin
                frame_prev <= frame;
                if (start || aligned) begin
                    aligned <= 1'b1;
                    idx     <= cur_idx + 3'h1;
                    set_bad <= set_done ? 1'b0 : set_err;
                end
            end
            if (|diff)
                err_detected <= 1'b1;
            else if (clr_err)
                err_detected <= 1'b0;
            if (!auto_mode) begin
                cmp_pass   <= 1'b0;
                cmp_fail   <= 1'b0;
                clean_sets <= 4'h0;
                armed      <= 1'b0;
            end else if (set_done && set_err) begin
                clean_sets <= 4'h0;
                cmp_pass   <= 1'b0;
                if (armed)
                    cmp_fail <= 1'b1;
            end else if (eight_ok) begin
                clean_sets <= `PASS_SETS;
                cmp_pass   <= 1'b1;
                armed      <= 1'b1;
                cmp_fail   <= 1'b0;
            end else begin
                if (set_ok && clean_sets != `PASS_SETS)
                    clean_sets <= clean_sets + 4'h1;
                if (clr_pass)
                    cmp_pass <= 1'b0;
                if (clr_fail)
                    cmp_fail <= 1'b0;
            end
        end
    end
endmodule // sample_checker

// ### rtl/event_irq_top.v
// Functional notes
// - Alert pin is open drain: pulled low when asserted, otherwise released.
// - Event flags live in two registers at offsets 0x06 and 0x07.
// - Each event flag has its own alert enable in 0x04 and 0x05.
// - Enabled flag latches on source rising edge and asserts the alert.
// - Disabled flag follows its live source and never drives the alert.
// - Writing one to a flag bit clears the latched flag.
// - Hardware or software reset clears all latched flags.
// - Writing a flag bit also clears its latched underlying source.
// - Checker compares captured input bytes with software loaded values.
// - One comparison set is four 16-bit words sent as eight bytes.
// - Word marker held one sample marks first in-phase word; checker aligns.
// - Marker accepted once at start or repeated on the first words.
// - Any mismatch sets error detected bit 5 of 0x67 until cleared.
// - Per-bit error history in 0x70 to 0x73 latches until cleared.
// - Pass and fail bits work only in auto clear mode.
// - Pass sets after eight consecutive error-free comparison sets.
// - Fail sets on error, but only after pass has been seen once.
// - Armed fail clears itself after eight clean sets.
// - Auto clear mode zeroes error history after eight clean sets.
// - Checker flags are mirrored in 0x07 and may raise the alert.
//
// Purpose: Event flags, host alert pin, sample checker and serial register port
// Assumes: Serial clock high and low each last at least four clk periods
// Notes:   One byte per serial frame; read data leaves on falling serial edges
`timescale 1ns/10ps
`include "event_irq_defines.vh"
module event_irq_top (
    input  wire       clk,
    input  wire       reset,
    input  wire       spi_clk,
    input  wire       spi_cs_n,
    input  wire       spi_data_in,
    output reg        spi_data_out,
    output reg        spi_data_oe_n,
    output reg        alert_out,
    output reg        alert_oe_n,
    input  wire [7:0] event_source_a,
    input  wire [7:3] event_source_b,
    output reg  [7:0] source_clear_a,
    output reg  [7:3] source_clear_b,
    input  wire [7:0] sample_data,
    input  wire       sample_valid,
    input  wire       sample_frame
);
    // Pin synchronisers, first stage read only by the second
    reg  [2:0] pin_meta;
    reg  [2:0] pin_sync;
    reg  [7:0] data_meta;
    reg  [7:0] data_sync;
    reg  [1:0] samp_meta;
    reg  [1:0] samp_sync;
    reg        spi_clk_prev;

    // Serial port
    reg  [4:0] bit_count;
    reg  [7:0] shift_in;
    reg  [7:0] shift_out;
    reg        read_op;
    reg  [6:0] addr;
    reg        wr_stb;
    reg  [6:0] wr_addr;
    reg  [7:0] wr_data;
    reg  [7:0] read_mux;

    // Register storage
    reg  [7:0] alert_en_a;
    reg  [7:0] alert_en_b;
    reg  [7:0] check_ctrl;
    reg  [7:0] cmp_bytes [0:7];
    reg        soft_rst;

    wire       cs_n_s   = pin_sync[0];
    wire       sclk_s   = pin_sync[1];
    wire       sdin_s   = pin_sync[2];
    wire       sclk_rise = sclk_s && !spi_clk_prev;
    wire       sclk_fall = !sclk_s && spi_clk_prev;

    wire [7:0] flags_a;
    wire [7:0] flags_b;
    wire       pending_a;
    wire       pending_b;
    wire       err_detected;
    wire       cmp_pass;
    wire       cmp_fail;
    wire [31:0] history;
    wire [63:0] cmp_set;

    wire       wr_ev_a  = wr_stb && (wr_addr == `ADDR_EVENT_A);
    wire       wr_ev_b  = wr_stb && (wr_addr == `ADDR_EVENT_B);
    wire       wr_chk   = wr_stb && (wr_addr == `ADDR_CHECK_CTRL);
    wire [7:0] clr_a    = wr_ev_a ? wr_data : 8'h00;
    wire [7:0] clr_b    = wr_ev_b ? wr_data : 8'h00;
    wire [7:0] clr_chk  = wr_chk ? wr_data : 8'h00;

    // Checker flags feed the low bits of the second bank
    wire [7:0] source_b = {event_source_b, err_detected, cmp_fail, cmp_pass};

    // Writing the mirrored bit clears the checker flag underneath it too
    wire clr_err  = clr_b[`EVB_ERR_DETECTED] | clr_chk[`CHK_ERR_DETECTED];
    wire clr_fail = clr_b[`EVB_FAIL] | clr_chk[`CHK_FAIL];
    wire clr_pass = clr_b[`EVB_PASS] | clr_chk[`CHK_PASS];

    wire [31:0] hist_clr;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_cmp
            assign cmp_set[g*8 +: 8] = cmp_bytes[g];
        end
        for (g = 0; g < 4; g = g + 1) begin : g_hist
            assign hist_clr[g*8 +: 8] =
                (wr_stb && wr_addr == `ADDR_HIST_FIRST + g) ? wr_data : 8'h00;
        end
    endgenerate

    always @(posedge clk) begin
        if (reset) begin
            pin_meta     <= 3'h1;
            pin_sync     <= 3'h1;
            data_meta    <= 8'h00;
            data_sync    <= 8'h00;
            samp_meta    <= 2'h0;
            samp_sync    <= 2'h0;
            spi_clk_prev <= 1'b0;
        end else begin
            pin_meta     <= {spi_data_in, spi_clk, spi_cs_n};
            pin_sync     <= pin_meta;
            data_meta    <= sample_data;
            data_sync    <= data_meta;
            samp_meta    <= {sample_frame, sample_valid};
            samp_sync    <= samp_meta;
            spi_clk_prev <= sclk_s;
        end
    end

    // Serial frame: R/W bit, 7-bit address, then one data byte, MSB first
    always @(posedge clk) begin
        if (reset) begin
            bit_count     <= 5'h00;
            shift_in      <= 8'h00;
            shift_out     <= 8'h00;
            read_op       <= 1'b0;
            addr          <= 7'h00;
            wr_stb        <= 1'b0;
            wr_addr       <= 7'h00;
            wr_data       <= 8'h00;
            spi_data_out  <= 1'b0;
            spi_data_oe_n <= 1'b1;
        end else begin
            wr_stb <= 1'b0;
            if (cs_n_s) begin
                bit_count     <= 5'h00;
                spi_data_oe_n <= 1'b1;
            end else begin
                if (sclk_rise && bit_count != `FRAME_BITS) begin
                    shift_in  <= {shift_in[6:0], sdin_s};
                    bit_count <= bit_count + 5'h01;
                    if (bit_count == `INSTR_BITS - 1) begin
                        read_op <= shift_in[6];
                        addr    <= {shift_in[5:0], sdin_s};
                    end
                    if (bit_count == `FRAME_BITS - 1 && !read_op) begin
                        wr_stb  <= 1'b1;
                        wr_addr <= addr;
                        wr_data <= {shift_in[6:0], sdin_s};
                    end
                end
                // Read data bit 7 is taken on the first data fall, bits 6:0 on the next rise, so a flag change between them can tear a byte
                if (sclk_rise && bit_count == `INSTR_BITS)
                    shift_out <= {read_mux[6:0], 1'b0};
                if (sclk_fall && bit_count == `INSTR_BITS && read_op) begin
                    spi_data_out  <= read_mux[7];
                    spi_data_oe_n <= 1'b0;
                end else if (sclk_fall && read_op && bit_count > `INSTR_BITS &&
                             bit_count < `FRAME_BITS) begin
                    spi_data_out <= shift_out[7];
                    shift_out    <= {shift_out[6:0], 1'b0};
                end else if (sclk_fall && bit_count == `FRAME_BITS) begin
                    spi_data_oe_n <= 1'b1;
                end
            end
        end
    end

    always @* begin
        read_mux = 8'h00;
        case (addr)
            `ADDR_ALERT_EN_A: read_mux = alert_en_a;
            `ADDR_ALERT_EN_B: read_mux = alert_en_b;
            `ADDR_EVENT_A:    read_mux = flags_a;
            `ADDR_EVENT_B:    read_mux = flags_b;
            `ADDR_CHECK_CTRL: read_mux = {check_ctrl[7:6], err_detected, check_ctrl[4:2],
                                          cmp_fail, cmp_pass};
            default: begin
                if (addr >= `ADDR_CMP_FIRST && addr <= `ADDR_CMP_LAST)
                    read_mux = cmp_bytes[addr[2:0]];
                else if (addr >= `ADDR_HIST_FIRST && addr <= `ADDR_HIST_LAST)
                    read_mux = history[addr[1:0]*8 +: 8];
            end
        endcase
    end

    integer k;
    always @(posedge clk) begin
        if (reset) begin
            alert_en_a <= `RST_ALERT_EN;
            alert_en_b <= `RST_ALERT_EN;
            check_ctrl <= `RST_CHECK_CTRL;
            soft_rst   <= 1'b0;
            for (k = 0; k < 8; k = k + 1)
                cmp_bytes[k] <= `RST_CMP_BYTE;
        end else begin
            soft_rst <= wr_stb && (wr_addr == `ADDR_CONFIG) && wr_data[`CFG_SOFT_RESET];
            if (soft_rst) begin
                alert_en_a <= `RST_ALERT_EN;
                alert_en_b <= `RST_ALERT_EN;
                check_ctrl <= `RST_CHECK_CTRL;
            end else if (wr_stb) begin
                if (wr_addr == `ADDR_ALERT_EN_A)
                    alert_en_a <= wr_data;
                if (wr_addr == `ADDR_ALERT_EN_B)
                    alert_en_b <= wr_data;
                // Status bits of this register are write-one-clear, not stored
                if (wr_chk) begin
                    check_ctrl <= wr_data & 8'hDC;
                end
                if (wr_addr >= `ADDR_CMP_FIRST && wr_addr <= `ADDR_CMP_LAST)
                    cmp_bytes[wr_addr[2:0]] <= wr_data;
            end
        end
    end

    // Underlying latched sources are cleared by the same write
    always @(posedge clk) begin
        if (reset) begin
            source_clear_a <= 8'h00;
            source_clear_b <= 5'h00;
        end else begin
            source_clear_a <= clr_a;
            source_clear_b <= clr_b[7:3];
        end
    end

    event_flag_bank #(
        .WIDTH      (8)
    ) u_bank_a (
        .clk        (clk),
        .reset      (reset),
        .soft_rst   (soft_rst),
        .source     (event_source_a),
        .enable     (alert_en_a),
        .clear_ones (clr_a),
        .flag_view  (flags_a),
        .pending    (pending_a)
    );

    event_flag_bank #(
        .WIDTH      (8)
    ) u_bank_b (
        .clk        (clk),
        .reset      (reset),
        .soft_rst   (soft_rst),
        .source     (source_b),
        .enable     (alert_en_b),
        .clear_ones (clr_b),
        .flag_view  (flags_b),
        .pending    (pending_b)
    );

    sample_checker u_checker (
        .clk          (clk),
        .reset        (reset),
        .soft_rst     (soft_rst),
        .enable       (check_ctrl[`CHK_ENABLE]),
        .auto_mode    (check_ctrl[`CHK_AUTO_CLEAR]),
        .data         (data_sync),
        .valid        (samp_sync[0]),
        .frame        (samp_sync[1]),
        .cmp_set      (cmp_set),
        .clr_err      (clr_err),
        .clr_pass     (clr_pass),
        .clr_fail     (clr_fail),
        .hist_clr     (hist_clr),
        .err_detected (err_detected),
        .cmp_pass     (cmp_pass),
        .cmp_fail     (cmp_fail),
        .history      (history)
    );

    // Only ever pulls low, so several alert pins can share one pull-up
    always @(posedge clk) begin
        if (reset) begin
            alert_out  <= 1'b0;
            alert_oe_n <= 1'b1;
        end else begin
            alert_out  <= 1'b0;
            alert_oe_n <= !(pending_a || pending_b);
        end
    end
endmodule // event_irq_top

// ### sim/event_irq_top_properties.sv
// Purpose: Port assertions for the alert and checker block
// Assumes: Host raises cs_n at least ten clk after the last serial rise
// Notes:   Enables are internal, so alert timing is tied to any source edge
`timescale 1ns/10ps
module event_irq_top_properties (
    input wire       clk,
    input wire       reset,
    input wire       spi_clk,
    input wire       spi_cs_n,
    input wire       spi_data_in,
    input wire       spi_data_out,
    input wire       spi_data_oe_n,
    input wire       alert_out,
    input wire       alert_oe_n,
    input wire [7:0] event_source_a,
    input wire [7:3] event_source_b,
    input wire [7:0] source_clear_a,
    input wire [7:3] source_clear_b,
    input wire [7:0] sample_data,
    input wire       sample_valid,
    input wire       sample_frame
);
    reg  [12:0] src_q;
    reg  [3:0]  vld_age;
    wire        src_rise = |({event_source_b, event_source_a} & ~src_q);
    // Checker flags reach the pin through syncs, so allow a short age
    always @(posedge clk) begin
        src_q <= {event_source_b, event_source_a};
        if (reset || sample_valid) begin
            vld_age <= reset ? 4'hF : 4'h0;
        end else if (vld_age != 4'hF) begin
            vld_age <= vld_age + 4'h1;
        end
    end
    sequence oe_released;
        ##[0:4] spi_data_oe_n;
    endsequence
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    alert_drive_zero_a : assert property (alert_out == 1'b0)
        else $error("alert pin driven high");
    clear_a_pulse_a : assert property (|source_clear_a |=> source_clear_a == 8'h00)
        else $error("source clear a longer than one cycle");
    clear_b_pulse_a : assert property (|source_clear_b |=> source_clear_b == 5'h00)
        else $error("source clear b longer than one cycle");
    clear_in_frame_a : assert property (|{source_clear_b, source_clear_a} |-> !spi_cs_n)
        else $error("source clear outside a serial write");
    reset_idle_a : assert property ($fell(reset) |-> alert_oe_n && spi_data_oe_n
        && source_clear_a == 8'h00) else $error("outputs not idle after reset");
    alert_cause_a : assert property ($fell(alert_oe_n) |-> $past(src_rise, 2)
        || vld_age < 4'hC) else $error("alert without a source edge");
    alert_release_a : assert property ($rose(alert_oe_n) |-> !spi_cs_n)
        else $error("alert released without a write");
    oe_after_cs_a : assert property ($rose(spi_cs_n) |-> oe_released)
        else $error("serial data still driven after deselect");
endmodule // event_irq_top_properties

bind event_irq_top event_irq_top_properties chk (.clk(clk), .reset(reset), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .spi_data_in(spi_data_in), .spi_data_out(spi_data_out),
    .spi_data_oe_n(spi_data_oe_n), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
    .event_source_a(event_source_a), .event_source_b(event_source_b),
    .source_clear_a(source_clear_a), .source_clear_b(source_clear_b),
    .sample_data(sample_data), .sample_valid(sample_valid), .sample_frame(sample_frame));

// ### sim/host_model.sv
// Purpose: Host side of the serial register port
// Assumes: Five clk high and six clk low per serial bit, clock idles low
// Notes:   Undriven read line is modelled as the inverse of the last bit
`timescale 1ns/10ps
module host_model (
    input  wire clk,
    output reg  spi_clk,
    output reg  spi_cs_n,
    output reg  spi_data_in,
    input  wire spi_data_out,
    input  wire spi_data_oe_n
);
    reg last;
    initial begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_data_in = 1'b0;
        last = 1'b0;
    end
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task xfer(input [7:0] inst, input [7:0] wd, output [7:0] rd);
        reg     [15:0] f;
        integer        i;
        begin
            f = {inst, wd};
            rd = 8'h00;
            @(posedge clk) spi_cs_n <= 1'b0;
            for (i = 15; i >= 0; i = i - 1) begin
                @(posedge clk) spi_data_in <= f[i];
                tick(5);
                if (i < 8) begin
                    rd[i] = spi_data_oe_n ? ~last : spi_data_out;
                    last = rd[i];
                end
                spi_clk <= 1'b1;
                tick(5);
                spi_clk <= 1'b0;
            end
            @(posedge clk) spi_data_in <= ~f[0];
            tick(5);
            spi_cs_n <= 1'b1;
            tick(5);
        end
    endtask
endmodule // host_model

// ### sim/event_irq_and_sample_check_tb_top.sv
// Purpose: Self-checking bench for the alert and checker block
// Assumes: Host model owns the serial pins, bench drives sources and samples
// Notes:   Comparison bytes chosen to toggle many bits
`timescale 1ns/10ps
`include "event_irq_defines.vh"
module event_irq_and_sample_check_tb_top;
    reg        clk, reset, svalid, sframe;
    reg  [7:0] src_a, sdata, rd;
    reg  [7:3] src_b;
    wire       spi_clk, spi_cs_n, spi_data_in, spi_data_out, spi_data_oe_n;
    wire       alert_out, alert_oe_n;
    wire [7:0] clr_a;
    wire [7:3] clr_b;
    wire       irq_n = alert_oe_n ? 1'b1 : alert_out;
    integer    fail_count, checked, i;
    event_irq_top dut (.clk(clk), .reset(reset), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
        .spi_data_in(spi_data_in), .spi_data_out(spi_data_out),
        .spi_data_oe_n(spi_data_oe_n), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
        .event_source_a(src_a), .event_source_b(src_b), .source_clear_a(clr_a),
        .source_clear_b(clr_b), .sample_data(sdata), .sample_valid(svalid),
        .sample_frame(sframe));
    host_model host (.clk(clk), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
        .spi_data_in(spi_data_in), .spi_data_out(spi_data_out),
        .spi_data_oe_n(spi_data_oe_n));
    always #50 clk = ~clk;
    function [7:0] cmpb(input [2:0] k);
        cmpb = 8'hA5 ^ {k, 2'h0, k};
    endfunction
    task stop_test;
        begin
            $display("checked %0d fail_count %0d", checked, fail_count);
            if (fail_count == 0 && checked > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task check(input string name, input [7:0] seen, input [7:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task wr(input [6:0] a, input [7:0] d);
        host.xfer({1'b0, a}, d, rd);
    endtask
    task rchk(input string n, input [6:0] a, input [7:0] e);
        begin
            host.xfer({1'b1, a}, 8'h00, rd);
            check(n, rd, e);
        end
    endtask
    // Frame marks the first byte of every set
    task send_set(input [7:0] flip);
        integer k;
        for (k = 0; k < 8; k = k + 1) begin
            @(posedge clk);
            sdata <= cmpb(k) ^ ((k == 0) ? flip : 8'h00);
            svalid <= 1'b1;
            sframe <= (k == 0);
            @(posedge clk) svalid <= 1'b0;
        end
    endtask
    task t_reset_values;
        begin
            rchk("alert_enable_a", `ADDR_ALERT_EN_A, `RST_ALERT_EN);
            rchk("check_control", `ADDR_CHECK_CTRL, `RST_CHECK_CTRL);
            rchk("unmapped", 7'h10, 8'h00);
        end
    endtask
    task t_alert;
        begin
            wr(`ADDR_ALERT_EN_A, 8'h01);
            rchk("alert_enable_a", `ADDR_ALERT_EN_A, 8'h01);
            @(posedge clk) src_a <= 8'h01;
            host.tick(4);
            check("alert", {7'h00, irq_n}, 8'h00);
            src_a <= 8'h02;
            rchk("event_flags_a", `ADDR_EVENT_A, 8'h03);
            src_b <= 5'h01;
            rchk("event_flags_b", `ADDR_EVENT_B, 8'h08);
            wr(`ADDR_EVENT_A, 8'h01);
            host.tick(3);
            check("alert", {7'h00, irq_n}, 8'h01);
            rchk("event_flags_a", `ADDR_EVENT_A, 8'h02);
            src_a <= 8'h03;
            host.tick(4);
            check("alert", {7'h00, irq_n}, 8'h00);
            wr(`ADDR_CONFIG, 8'h20);
            host.tick(3);
            check("alert", {7'h00, irq_n}, 8'h01);
            rchk("alert_enable_a", `ADDR_ALERT_EN_A, 8'h00);
            // Upper source bits, live first, then one latched edge and a hardware reset
            src_a <= 8'hFC;
            src_b <= 5'h1E;
            rchk("event_flags_a", `ADDR_EVENT_A, 8'hFC);
            rchk("event_flags_b", `ADDR_EVENT_B, 8'hF0);
            wr(`ADDR_ALERT_EN_B, 8'hF8);
            src_b <= 5'h00;
            host.tick(2);
            src_b <= 5'h10;
            host.tick(4);
            check("alert", {7'h00, irq_n}, 8'h00);
            rchk("event_flags_b", `ADDR_EVENT_B, 8'h80);
            reset <= 1'b1;
            host.tick(3);
            reset <= 1'b0;
            src_b <= 5'h01;
            host.tick(3);
            check("alert", {7'h00, irq_n}, 8'h01);
            rchk("alert_enable_b", `ADDR_ALERT_EN_B, 8'h00);
        end
    endtask
    task t_checker;
        begin
            for (i = 0; i < 8; i = i + 1) wr(`ADDR_CMP_FIRST + i, cmpb(i));
            wr(`ADDR_CHECK_CTRL, 8'h88);
            wr(`ADDR_CHECK_CTRL, 8'hAB);
            repeat (8) send_set(8'h00);
            rchk("check_control", `ADDR_CHECK_CTRL, 8'h89);
            send_set(8'h01);
            rchk("check_control", `ADDR_CHECK_CTRL, 8'hAA);
            rchk("bit_error_history_0", `ADDR_HIST_FIRST, 8'h01);
            rchk("event_flags_b", `ADDR_EVENT_B, 8'h0E);
            repeat (8) send_set(8'h00);
            rchk("check_control", `ADDR_CHECK_CTRL, 8'hA9);
            rchk("bit_error_history_0", `ADDR_HIST_FIRST, 8'h00);
            wr(`ADDR_ALERT_EN_B, 8'h04);
            wr(`ADDR_CHECK_CTRL, 8'hA8);
            send_set(8'h80);
            host.tick(10);
            check("alert", {7'h00, irq_n}, 8'h00);
            rchk("bit_error_history_0", `ADDR_HIST_FIRST, 8'h80);
        end
    endtask
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        src_a = 8'h00;
        src_b = 5'h00;
        sdata = 8'h00;
        svalid = 1'b0;
        sframe = 1'b0;
        fail_count = 0;
        checked = 0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        host.tick(3);
        t_reset_values;
        t_alert;
        t_checker;
        stop_test;
    end
    // Hang guard well above the longest run
    initial begin
        repeat (90000) @(posedge clk);
        fail_count = fail_count + 1;
        stop_test;
    end
endmodule // event_irq_and_sample_check_tb_top
